// *** design/lecg_pkg.sv ***
// package of constants for the link endpoint configuration gate
package lecg_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_SCNT = 4'h8;
    // control field positions and reset value
    localparam int CTRL_LINK_CFG = 0;
    localparam int CTRL_AUTON = 1;
    localparam int CTRL_AUTO_RESTART = 2;
    localparam int CTRL_START = 3;
    localparam logic [2:0] CTRL_RESET = 3'h3;
    // completion status codes
    localparam logic [1:0] CPL_SC = 2'h0;
    localparam logic [1:0] CPL_UR = 2'h1;
    localparam logic [1:0] CPL_CRS = 2'h2;
    // request kinds
    localparam logic REQ_CFG = 1'b0;
    localparam logic REQ_MEM = 1'b1;
    // restart hold time in cycles
    localparam int RESTART_HOLD_NS = 40;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESTART_HOLD_CYC = (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // configuration phases
    typedef enum logic [2:0] {
        LECG_IDLE,
        LECG_PERIPH,
        LECG_CORE,
        LECG_USER,
        LECG_ERROR
    } lecg_phase_t;
endpackage : lecg_pkg

// *** design/lecg_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module lecg_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : lecg_sync

// *** design/lecg_top.sv ***
// configuration gate for the hardened link endpoint
//
// Behaviour
// - in autonomous operation, endpoint leaves reset once periphery image is loaded.
// - with link configuration enabled, requests get normal completion during core load.
// - non-link core source, autonomous: configuration requests get retry status.
// - non-link core source, autonomous: memory requests get unsupported request status.
// - non-link core source, not autonomous: endpoint stays in reset until user mode.
// - non-autonomous: link training waits for user mode.
// - autonomous choice matters only for non-link core with link config disabled.
// - with auto restart enabled, a configuration error restarts the sequence.
// - autonomous setting only affects the initial configuration.
// - core image arrives over the link in initialization and update modes.
`timescale 1ns/1ns
module lecg_top #(
    parameter int HOLD_CYC = lecg_pkg::RESTART_HOLD_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // configuration sequencer pins
    input wire logic periph_done_i,
    input wire logic core_done_i,
    input wire logic cfg_error_i,
    // core image over the link
    input wire logic core_valid_i,
    input wire logic [31:0] core_data_i,
    output logic core_valid_o,
    output logic [31:0] core_data_o,
    // endpoint control
    output logic ep_reset_o,
    output logic train_en_o,
    output logic user_mode_o,
    output logic cfg_restart_o,
    // request and completion
    input wire logic req_valid_i,
    input wire logic req_kind_i,
    output logic cpl_valid_o,
    output logic [1:0] cpl_status_o
);
    logic [2:0] ctrl_reg;
    logic [15:0] restart_cnt_reg;
    logic periph_s;
    logic core_s;
    logic err_s;
    logic err_d_reg;
    logic initial_reg;
    logic auton_eff;
    logic auton_latch_reg;
    logic [7:0] hold_reg;
    logic start_pulse;
    logic wr_ctrl;
    logic bus_req;
    logic [1:0] status_next;
    lecg_pkg::lecg_phase_t phase_reg;

    lecg_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({periph_done_i, core_done_i, cfg_error_i}),
        .q_o({periph_s, core_s, err_s})
    );

    assign bus_req = cyc_i && stb_i && !ack_o && !err_o;
    // a write lands at the edge where the master sees ack, not at the take edge
    assign wr_ctrl = cyc_i && stb_i && ack_o && we_i && (adr_i == lecg_pkg::ADDR_CTRL)
        && sel_i[0];
    assign start_pulse = wr_ctrl && dat_i[lecg_pkg::CTRL_START];

    // effective autonomy: forced on unless non-link core and link config off
    assign auton_eff = ctrl_reg[lecg_pkg::CTRL_LINK_CFG] || ctrl_reg[lecg_pkg::CTRL_AUTON];

    // wishbone register access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= lecg_pkg::CTRL_RESET;
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            if (wr_ctrl) begin
                ctrl_reg <= dat_i[2:0];
            end
            if (bus_req) begin
                case (adr_i)
                    lecg_pkg::ADDR_CTRL: begin
                        ack_o <= 1'b1;
                        dat_o <= {29'h0, ctrl_reg};
                    end
                    lecg_pkg::ADDR_STAT: begin
                        ack_o <= 1'b1;
                        dat_o <= {24'h0, 3'h0, initial_reg, auton_latch_reg, 3'(phase_reg)};
                    end
                    lecg_pkg::ADDR_SCNT: begin
                        ack_o <= 1'b1;
                        dat_o <= {16'h0, restart_cnt_reg};
                    end
                    default: begin
                        err_o <= 1'b1;
                        dat_o <= 32'h0;
                    end
                endcase
            end
        end
    end

    // configuration phase sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= lecg_pkg::LECG_PERIPH;
            err_d_reg <= 1'b0;
            hold_reg <= 8'h0;
            restart_cnt_reg <= 16'h0;
            cfg_restart_o <= 1'b0;
        end else begin
            err_d_reg <= err_s;
            cfg_restart_o <= 1'b0;
            if (err_s && !err_d_reg && phase_reg != lecg_pkg::LECG_USER) begin
                phase_reg <= lecg_pkg::LECG_ERROR;
                hold_reg <= 8'(HOLD_CYC);
            end else begin
                case (phase_reg)
                    lecg_pkg::LECG_IDLE: begin
                        if (start_pulse) begin
                            phase_reg <= lecg_pkg::LECG_PERIPH;
                        end
                    end
                    lecg_pkg::LECG_PERIPH: begin
                        if (periph_s) begin
                            phase_reg <= lecg_pkg::LECG_CORE;
                        end
                    end
                    lecg_pkg::LECG_CORE: begin
                        if (core_s) begin
                            phase_reg <= lecg_pkg::LECG_USER;
                        end
                    end
                    lecg_pkg::LECG_USER: begin
                        if (start_pulse) begin
                            phase_reg <= lecg_pkg::LECG_CORE;
                        end
                    end
                    lecg_pkg::LECG_ERROR: begin
                        if (hold_reg != 8'h0) begin
                            hold_reg <= hold_reg - 8'h1;
                        end else if (ctrl_reg[lecg_pkg::CTRL_AUTO_RESTART]) begin
                            phase_reg <= lecg_pkg::LECG_PERIPH;
                            cfg_restart_o <= 1'b1;
                            restart_cnt_reg <= restart_cnt_reg + 16'h1;
                        end else if (start_pulse) begin
                            phase_reg <= lecg_pkg::LECG_PERIPH;
                        end
                    end
                    default: begin
                        phase_reg <= lecg_pkg::LECG_IDLE;
                    end
                endcase
            end
        end
    end

    // initial configuration flag and latched autonomy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            initial_reg <= 1'b1;
            auton_latch_reg <= 1'b1;
        end else begin
            if (phase_reg == lecg_pkg::LECG_USER) begin
                initial_reg <= 1'b0;
            end
            if (phase_reg == lecg_pkg::LECG_PERIPH && initial_reg) begin
                auton_latch_reg <= auton_eff;
            end
        end
    end

    // endpoint reset and training enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ep_reset_o <= 1'b1;
            train_en_o <= 1'b0;
            user_mode_o <= 1'b0;
        end else begin
            user_mode_o <= (phase_reg == lecg_pkg::LECG_USER);
            case (phase_reg)
                lecg_pkg::LECG_CORE: begin
                    if (!initial_reg || auton_latch_reg) begin
                        ep_reset_o <= 1'b0;
                        train_en_o <= 1'b1;
                    end else begin
                        ep_reset_o <= 1'b1;
                        train_en_o <= 1'b0;
                    end
                end
                lecg_pkg::LECG_USER: begin
                    ep_reset_o <= 1'b0;
                    train_en_o <= 1'b1;
                end
                default: begin
                    ep_reset_o <= 1'b1;
                    train_en_o <= 1'b0;
                end
            endcase
        end
    end

    // completion status choice
    always_comb begin
        status_next = lecg_pkg::CPL_SC;
        if (phase_reg == lecg_pkg::LECG_CORE && initial_reg
            && !ctrl_reg[lecg_pkg::CTRL_LINK_CFG]) begin
            if (req_kind_i == lecg_pkg::REQ_CFG) begin
                status_next = lecg_pkg::CPL_CRS;
            end else begin
                status_next = lecg_pkg::CPL_UR;
            end
        end
        // link config during load and user mode both complete normally
    end

    // completions, only while the endpoint is out of reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpl_valid_o <= 1'b0;
            cpl_status_o <= lecg_pkg::CPL_SC;
        end else begin
            cpl_valid_o <= req_valid_i && !ep_reset_o;
            if (req_valid_i && !ep_reset_o) begin
                cpl_status_o <= status_next;
            end
        end
    end

    // core image words from the link forwarded to the loader
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_valid_o <= 1'b0;
            core_data_o <= 32'h0;
        end else begin
            core_valid_o <= core_valid_i && !ep_reset_o
                && ctrl_reg[lecg_pkg::CTRL_LINK_CFG]
                && (phase_reg == lecg_pkg::LECG_CORE);
            if (core_valid_i) begin
                core_data_o <= core_data_i;
            end
        end
    end
endmodule : lecg_top

// *** dv/lecg_rp.sv ***
// root port model issuing requests and core words
`timescale 1ns/1ns
module lecg_rp (
    // clock
    input logic clk_i,
    // requests and completions
    output logic req_valid_o,
    output logic req_kind_o,
    input logic cpl_valid_i,
    input logic [1:0] cpl_status_i,
    // core image words
    output logic core_valid_o,
    output logic [31:0] core_data_o
);
    initial begin
        req_valid_o = 1'h0;
        req_kind_o = 1'h0;
        core_valid_o = 1'h0;
        core_data_o = 32'h0;
    end
    // idle lines show the inverse of the last value
    task req(input logic k, output logic v, output logic [1:0] s);
        @(posedge clk_i);
        req_valid_o <= 1'h1;
        req_kind_o <= k;
        @(posedge clk_i);
        req_valid_o <= 1'h0;
        req_kind_o <= ~k;
        #1 v = cpl_valid_i;
        s = cpl_status_i;
    endtask : req
    task word(input logic [31:0] d);
        @(posedge clk_i);
        core_valid_o <= 1'h1;
        core_data_o <= d;
        @(posedge clk_i);
        core_valid_o <= 1'h0;
        core_data_o <= ~d;
        #1;
    endtask : word
endmodule : lecg_rp

// *** dv/lecg_top_asserts.sv ***
// port assertions for the configuration gate
`timescale 1ns/1ns
module lecg_top_asserts (
    // clock and reset
    input logic clk_i,
    input logic rst_i,
    // bus
    input logic cyc_i,
    input logic stb_i,
    input logic [3:0] adr_i,
    input logic ack_o,
    input logic err_o,
    // link side
    input logic core_valid_i,
    input logic [31:0] core_data_i,
    input logic core_valid_o,
    input logic [31:0] core_data_o,
    input logic req_valid_i,
    input logic cpl_valid_o,
    input logic [1:0] cpl_status_o,
    // endpoint control
    input logic ep_reset_o,
    input logic train_en_o,
    input logic user_mode_o,
    input logic cfg_restart_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    bus_answer_a: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o)
        else $error("bus access not answered in one cycle");
    err_map_a: assert property (err_o |-> !($past(adr_i) inside {4'h0, 4'h4, 4'h8}))
        else $error("error answer on a mapped address");
    cpl_cause_a: assert property (cpl_valid_o |-> $past(req_valid_i && !ep_reset_o))
        else $error("completion without a request taken");
    cpl_resp_a: assert property (req_valid_i && !ep_reset_o |=> cpl_valid_o)
        else $error("request not completed");
    user_sc_a: assert property (cpl_valid_o && $past(user_mode_o) |-> !cpl_status_o)
        else $error("abnormal completion in user mode");
    train_gate_a: assert property (train_en_o |-> !ep_reset_o)
        else $error("training allowed while endpoint held");
    user_rst_a: assert property (user_mode_o |=> !ep_reset_o)
        else $error("endpoint held in user mode");
    restart_pulse_a: assert property (cfg_restart_o |-> ep_reset_o ##1 !cfg_restart_o)
        else $error("restart pulse malformed");
    core_fwd_a: assert property (core_valid_o |-> $past(core_valid_i)
        && core_data_o == $past(core_data_i))
        else $error("forwarded core word wrong");
    cover property (cpl_valid_o && cpl_status_o == lecg_pkg::CPL_CRS);
    cover property (cpl_valid_o && cpl_status_o == lecg_pkg::CPL_UR);
    cover property (cfg_restart_o);
endmodule : lecg_top_asserts

// *** dv/test_link_endpoint_config_gate.sv ***
// self-checking bench for the configuration gate
`timescale 1ns/1ns
module test_link_endpoint_config_gate;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, e, v;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, r, dat_o, core_data_i, core_data_o;
    logic periph_done_i = 0, core_done_i = 0, cfg_error_i = 0;
    logic req_valid_i, req_kind_i, core_valid_i, ack_o, err_o, core_valid_o;
    logic ep_reset_o, train_en_o, user_mode_o, cfg_restart_o, cpl_valid_o;
    logic [1:0] cpl_status_o, s;
    int fails = 0, cmp_count = 0;
    initial forever #2 clk_i = ~clk_i;
    lecg_top #(.HOLD_CYC(3)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .err_o, .periph_done_i, .core_done_i,
        .cfg_error_i, .core_valid_i, .core_data_i, .core_valid_o, .core_data_o,
        .ep_reset_o, .train_en_o, .user_mode_o, .cfg_restart_o, .req_valid_i,
        .req_kind_i, .cpl_valid_o, .cpl_status_o);
    lecg_rp u_rp (.clk_i, .req_valid_o(req_valid_i), .req_kind_o(req_kind_i),
        .cpl_valid_i(cpl_valid_o), .cpl_status_i(cpl_status_o),
        .core_valid_o(core_valid_i), .core_data_o(core_data_i));
    task give_verdict;
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask : chk
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 20);
        r = dat_o;
        e = err_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        if (n >= 20) fails++;
    endtask : wb
    task pins(input logic p, input logic c);
        @(posedge clk_i);
        periph_done_i <= p;
        core_done_i <= c;
        repeat (6) @(posedge clk_i);
        #1;
    endtask : pins
    task rs(input logic [31:0] c);
        @(posedge clk_i);
        rst_i <= 1'h1;
        cfg_error_i <= 1'h0;
        pins(0, 0);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1, 4'h0, c);
    endtask : rs
    task s_auto;
        rs(32'h3);
        wb(0, 4'hc, 32'h0);
        chk("unmapped err", 1, e);
        pins(1, 0);
        chk("ep reset", 0, ep_reset_o);
        u_rp.req(lecg_pkg::REQ_CFG, v, s);
        chk("cfg cpl", 32'h4, {v, s});
        u_rp.req(lecg_pkg::REQ_MEM, v, s);
        chk("mem cpl", 32'h4, {v, s});
        u_rp.word(32'h5a5a0001);
        chk("core word", 32'h5a5a0001, core_data_o & {32{core_valid_o}});
    endtask : s_auto
    task s_crs;
        rs(32'h2);
        pins(1, 0);
        u_rp.req(lecg_pkg::REQ_CFG, v, s);
        chk("cfg cpl", 32'h6, {v, s});
        u_rp.req(lecg_pkg::REQ_MEM, v, s);
        chk("mem cpl", 32'h5, {v, s});
        u_rp.word(32'h0000a5a5);
        chk("dropped word", 0, core_valid_o);
        pins(1, 1);
        u_rp.req(lecg_pkg::REQ_CFG, v, s);
        chk("user cfg cpl", 32'h4, {v, s});
        pins(1, 0);
        wb(1, 4'h0, 32'ha);
        u_rp.req(lecg_pkg::REQ_CFG, v, s);
        chk("update cfg cpl", 32'h4, {v, s});
        chk("update ep reset", 0, ep_reset_o);
    endtask : s_crs
    task s_gate(input logic [31:0] c, input logic held);
        rs(c);
        pins(1, 0);
        chk("held ep", held, ep_reset_o);
        chk("held train", 0, train_en_o & held);
        u_rp.req(lecg_pkg::REQ_CFG, v, s);
        chk("held cpl", !held, v);
        pins(1, 1);
        chk("user ep", 0, ep_reset_o);
        chk("user train", 1, train_en_o);
        chk("user mode", 1, user_mode_o);
    endtask : s_gate
    task s_err;
        int n;
        rs(32'h4);
        pins(1, 0);
        cfg_error_i <= 1'h1;
        n = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (cfg_restart_o === 1'h1) n++;
        end
        chk("restarts", 1, n);
        wb(0, 4'h8, 32'h0);
        chk("restart count", 1, r);
    endtask : s_err
    initial begin
        s_auto;
        s_crs;
        s_gate(32'h0, 1);
        s_gate(32'h1, 0);
        s_err;
        give_verdict;
    end
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule : test_link_endpoint_config_gate
bind lecg_top lecg_top_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .ack_o,
    .err_o, .core_valid_i, .core_data_i, .core_valid_o, .core_data_o, .req_valid_i,
    .cpl_valid_o, .cpl_status_o, .ep_reset_o, .train_en_o, .user_mode_o, .cfg_restart_o);
